// *** pkg/eeprom_pkg.sv ***
package eeprom_pkg;

  localparam int CLK_SYS_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  // Longest write times; counts round down
  localparam int T_WRITE_MS = 10;
  localparam int T_WRITE_LONG_MS = 20;
  localparam int WRITE_CYCLES = T_WRITE_MS * (CLK_SYS_HZ / MS_PER_S);
  localparam int WRITE_LONG_CYCLES = T_WRITE_LONG_MS * (CLK_SYS_HZ / MS_PER_S);
  localparam int TIMER_W = 24;

  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int PAGE_SLOTS = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_SLOT = 4'hF;

  // Select byte fields
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int CE_BIT = 3;
  localparam int BLOCK_HI = 2;
  localparam int BLOCK_LO = 1;
  localparam int RW_BIT = 0;

  // Protection byte at the top of memory
  localparam logic [ADDR_W-1:0] PROTECT_ADDR = 10'h3FF;
  localparam int PROTECT_FLAG_BIT = 2;
  localparam int BOUND_HI = 7;
  localparam int BOUND_LO = 4;
  localparam logic [1:0] TOP_BLOCK = 2'h3;
  localparam logic [3:0] BOUND_LOW_NIBBLE = 4'h0;
  localparam int ROW_LO = 3;

  typedef struct packed {
    logic chip_enable;
    logic protect_enable;
    logic mode;
    logic write_control;
  } pins_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SELECT = 4'h1,
    ST_SEL_ACK = 4'h2,
    ST_ADDR = 4'h3,
    ST_ADDR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_IGNORE = 4'h9,
    ST_COMMIT = 4'hA,
    ST_PROG = 4'hB
  } link_state_t;

endpackage

// *** logic/sync2.sv ***
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage feeds only the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// *** logic/write_timer.sv ***
`timescale 1ns/10ps
module write_timer #(
  parameter int SHORT_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter int LONG_CYCLES = eeprom_pkg::WRITE_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_tgl,
  input wire logic long_cycle,
  output logic busy,
  output logic done_tgl
);
  import eeprom_pkg::*;

  logic req_seen;
  logic [TIMER_W-1:0] count;
  logic start;

  assign start = req_tgl ^ req_seen;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_seen <= 1'b0;
    end else begin
      req_seen <= req_tgl;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done_tgl <= 1'b0;
      count <= '0;
    end else if (start) begin
      busy <= 1'b1;
      count <= long_cycle ? TIMER_W'(LONG_CYCLES - 1) : TIMER_W'(SHORT_CYCLES - 1);
    end else if (busy) begin
      if (count == '0) begin
        busy <= 1'b0;
        done_tgl <= ~done_tgl;
      end else begin
        count <= count - TIMER_W'(1);
      end
    end
  end

  a_timer_load: assert property (@(posedge clk_sys) disable iff (rst)
    start && !long_cycle |=> busy && count == TIMER_W'(SHORT_CYCLES - 1))
    else $error("write timer short load wrong");
endmodule

// *** logic/eeprom_i2c_slave.sv ***
`timescale 1ns/10ps
module eeprom_i2c_slave #(
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h5, // Arbitrary value
  parameter logic WC_VARIANT = 1'b0,
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter int WRITE_LONG_CYCLES = eeprom_pkg::WRITE_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire eeprom_pkg::pins_t pins,
  output logic busy
);
  import eeprom_pkg::*;

  logic rst_link;
  logic scl_s, sda_s, scl_d, sda_d;
  pins_t pins_s;
  logic scl_rise, scl_fall, start_c, stop_c;
  link_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic is_read;
  logic [ADDR_W-1:0] addr_ptr;
  logic [7:0] buf_data [PAGE_SLOTS];
  logic [ADDR_W-1:0] buf_addr [PAGE_SLOTS];
  logic [PAGE_SLOTS-1:0] buf_valid;
  logic [3:0] mb_cnt;
  logic [ADDR_W-1:ROW_LO] first_row;
  logic spans_rows;
  logic [3:0] commit_idx;
  logic req_tgl, long_req;
  logic done_s, done_seen;
  logic [7:0] mem [MEM_DEPTH];
  logic multibyte, match, in_prog;
  logic [7:0] protect_byte;
  logic [ADDR_W-1:0] boundary, commit_addr;
  logic commit_protected, write_blocked, mem_we;
  logic [1:0] req_sys;
  logic done_tgl;
  logic buf_we;
  logic [3:0] buf_slot;

  sync2 #(.WIDTH(1)) u_rst_sync (.clk(clk_link), .d(rst), .q(rst_link));
  sync2 #(.WIDTH(2)) u_bus_sync (.clk(clk_link), .d({scl_in, sda_in}), .q({scl_s, sda_s}));
  sync2 #(.WIDTH(4)) u_pin_sync (.clk(clk_link), .d(pins), .q(pins_s));
  sync2 #(.WIDTH(1)) u_done_sync (.clk(clk_link), .d(done_tgl), .q(done_s));
  sync2 #(.WIDTH(2)) u_req_sync (.clk(clk_sys), .d({req_tgl, long_req}), .q(req_sys));

  write_timer #(
    .SHORT_CYCLES(WRITE_CYCLES),
    .LONG_CYCLES(WRITE_LONG_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .req_tgl(req_sys[1]),
    .long_cycle(req_sys[0]),
    .busy(busy),
    .done_tgl(done_tgl)
  );

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  assign multibyte = pins_s.mode & ~WC_VARIANT;
  assign match = (shreg[TYPE_HI:TYPE_LO] == DEVICE_TYPE_ID)
    && (shreg[CE_BIT] == pins_s.chip_enable);
  assign in_prog = (state == ST_COMMIT) || (state == ST_PROG);

  // Protection is read live from the top byte, so a new boundary acts on the next command
  assign protect_byte = mem[PROTECT_ADDR];
  assign boundary = {TOP_BLOCK, protect_byte[BOUND_HI:BOUND_LO], BOUND_LOW_NIBBLE};
  assign commit_addr = buf_addr[commit_idx];
  assign commit_protected = pins_s.protect_enable && !protect_byte[PROTECT_FLAG_BIT]
    && (commit_addr >= boundary);
  assign write_blocked = WC_VARIANT && pins_s.write_control;
  assign mem_we = (state == ST_COMMIT) && buf_valid[commit_idx] && !commit_protected && !write_blocked;

  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clk_link) begin
    if (mem_we) begin
      mem[commit_addr] <= buf_data[commit_idx];
    end
  end

  // Slot follows the byte count in multibyte mode and the row offset in page mode
  assign buf_slot = multibyte ? mb_cnt : addr_ptr[3:0];
  assign buf_we = !rst_link && (state == ST_WDATA) && scl_fall && (bit_cnt == BITS_PER_BYTE);

  always_ff @(posedge clk_link) begin
    if (buf_we) begin
      buf_data[buf_slot] <= shreg;
      buf_addr[buf_slot] <= addr_ptr;
    end
  end

  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      done_seen <= 1'b0;
    end else begin
      done_seen <= done_s;
    end
  end

  // Open drain: only the enable moves, the driven level is low outside reset (high while rst_link is set)
  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      sda_out <= 1'b1;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      shreg <= '0;
      is_read <= 1'b0;
      addr_ptr <= '0;
      buf_valid <= '0;
      mb_cnt <= '0;
      first_row <= '0;
      spans_rows <= 1'b0;
      commit_idx <= '0;
      req_tgl <= 1'b0;
      long_req <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_c && !in_prog) begin
      state <= ST_SELECT;
      bit_cnt <= '0;
      sda_oe_n <= 1'b1;
    end else if (stop_c && !in_prog) begin
      sda_oe_n <= 1'b1;
      if ((state == ST_WDATA || state == ST_WDATA_ACK) && buf_valid != '0) begin
        state <= ST_COMMIT;
        commit_idx <= '0;
        // Settles long before the request toggles, so the pair never crosses skewed
        long_req <= spans_rows;
      end else begin
        state <= ST_IDLE;
      end
    end else begin
      unique case (state)
        ST_IDLE, ST_IGNORE: begin
          sda_oe_n <= 1'b1;
        end
        ST_SELECT, ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= '0;
            if (state == ST_SELECT) begin
              if (match) begin
                state <= ST_SEL_ACK;
                sda_oe_n <= 1'b0;
                addr_ptr[ADDR_W-1:ADDR_W-2] <= shreg[BLOCK_HI:BLOCK_LO];
                is_read <= shreg[RW_BIT];
              end else begin
                state <= ST_IGNORE;
              end
            end else if (state == ST_ADDR) begin
              state <= ST_ADDR_ACK;
              sda_oe_n <= 1'b0;
              addr_ptr[7:0] <= shreg;
            end else begin
              state <= ST_WDATA_ACK;
              sda_oe_n <= 1'b0;
              buf_valid[buf_slot] <= 1'b1;
              mb_cnt <= mb_cnt + 4'h1;
              if (buf_valid == '0) begin
                first_row <= addr_ptr[ADDR_W-1:ROW_LO];
              end else if (multibyte && addr_ptr[ADDR_W-1:ROW_LO] != first_row) begin
                spans_rows <= 1'b1;
              end
              if (multibyte) begin
                addr_ptr <= addr_ptr + ADDR_W'(1);
              end else begin
                addr_ptr[3:0] <= addr_ptr[3:0] + 4'h1;
              end
            end
          end
        end
        ST_SEL_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            if (is_read) begin
              state <= ST_RDATA;
              shreg <= mem[addr_ptr];
              sda_oe_n <= mem[addr_ptr][7];
              addr_ptr <= addr_ptr + ADDR_W'(1);
            end else begin
              state <= ST_ADDR;
              sda_oe_n <= 1'b1;
              buf_valid <= '0;
              mb_cnt <= '0;
              spans_rows <= 1'b0;
            end
          end
        end
        ST_ADDR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            state <= ST_WDATA;
            sda_oe_n <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state <= ST_RDATA_ACK;
              sda_oe_n <= 1'b1;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe_n <= shreg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          // Reuses the select ack step to load and drive the next byte
          if (scl_rise) begin
            state <= sda_s ? ST_IGNORE : ST_SEL_ACK;
          end
        end
        ST_COMMIT: begin
          commit_idx <= commit_idx + 4'h1;
          if (commit_idx == LAST_SLOT) begin
            state <= ST_PROG;
            req_tgl <= ~req_tgl;
          end
        end
        ST_PROG: begin
          if (done_s != done_seen) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  a_start_restarts: assert property (@(posedge clk_link) disable iff (rst_link)
    start_c && !in_prog |=> state == ST_SELECT && bit_cnt == '0)
    else $error("start did not restart select");

  a_busy_ignores: assert property (@(posedge clk_link) disable iff (rst_link)
    state == ST_PROG && start_c && done_s == done_seen |=> state == ST_PROG && sda_oe_n)
    else $error("start answered during write cycle");

  a_select_acked: assert property (@(posedge clk_link) disable iff (rst_link)
    state == ST_SELECT && scl_fall && bit_cnt == BITS_PER_BYTE && match && !start_c && !stop_c
    |=> state == ST_SEL_ACK && !sda_oe_n)
    else $error("matching select not acknowledged");

  a_select_ignored: assert property (@(posedge clk_link) disable iff (rst_link)
    state == ST_IGNORE && !start_c && !stop_c |=> sda_oe_n && state == ST_IGNORE)
    else $error("ignored transfer drove SDA");

  // A read normally ends in the ignore state after the host's NACK, so the read flag marks it
  a_stop_read_idle: assert property (@(posedge clk_link) disable iff (rst_link)
    stop_c && !in_prog && is_read |=> state == ST_IDLE && sda_oe_n)
    else $error("stop after read not standby");

  a_stop_commits: assert property (@(posedge clk_link) disable iff (rst_link)
    stop_c && (state == ST_WDATA || state == ST_WDATA_ACK) && buf_valid != '0
    |=> state == ST_COMMIT && commit_idx == '0)
    else $error("stop after write did not commit");

  a_commit_length: assert property (@(posedge clk_link) disable iff (rst_link)
    $rose(state == ST_COMMIT) |-> (state == ST_COMMIT)[*8] ##1 (state == ST_COMMIT)[*8] ##1 state == ST_PROG)
    else $error("commit walk length wrong");

  a_wc_blocks: assert property (@(posedge clk_link) disable iff (rst_link)
    mem_we |-> !(WC_VARIANT && pins_s.write_control))
    else $error("write under write control");

  a_protect_holds: assert property (@(posedge clk_link) disable iff (rst_link)
    mem_we && pins_s.protect_enable && !protect_byte[PROTECT_FLAG_BIT] |-> commit_addr < boundary)
    else $error("protected region written");

  a_ack_release: assert property (@(posedge clk_link) disable iff (rst_link)
    (state == ST_WDATA_ACK || state == ST_ADDR_ACK) && scl_fall && !start_c && !stop_c
    |=> sda_oe_n ##1 state == ST_WDATA)
    else $error("ack not released");

  a_page_wraps: assert property (@(posedge clk_link) disable iff (rst_link)
    state == ST_WDATA && scl_fall && bit_cnt == BITS_PER_BYTE && !multibyte && !start_c && !stop_c
    |=> $stable(addr_ptr[ADDR_W-1:4]))
    else $error("page write left its row");

  a_buffer_stores: assert property (@(posedge clk_link) disable iff (rst_link)
    buf_we |=> buf_valid[$past(buf_slot)] && buf_data[$past(buf_slot)] == $past(shreg))
    else $error("data byte not buffered");

  c_select_ack: cover property (@(posedge clk_link) disable iff (rst_link) $rose(state == ST_SEL_ACK));
  c_read_next: cover property (@(posedge clk_link) disable iff (rst_link)
    state == ST_RDATA_ACK ##1 state == ST_SEL_ACK);
  c_commit: cover property (@(posedge clk_link) disable iff (rst_link) state == ST_COMMIT ##1 mem_we);
  c_mismatch: cover property (@(posedge clk_link) disable iff (rst_link) $rose(state == ST_IGNORE));
endmodule

// *** tb/i2c_host.sv ***
`timescale 1ns/10ps
module i2c_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Quarter bit time; the bench raises it to 600 for some reads to stand in for a slow host
  int unsigned q = 150;
  logic r;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #q sda_low = !b;
    #q scl = 1'b1;
    #q s = sda;
    #q scl = 1'b0;
  endtask
  task automatic start();
    #q sda_low = 1'b0;
    #q scl = 1'b1;
    #(2 * q) sda_low = 1'b1;
    #(2 * q) scl = 1'b0;
  endtask
  task automatic stop();
    #q sda_low = 1'b1;
    #q scl = 1'b1;
    #(2 * q) sda_low = 1'b0;
    #(2 * q);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

// *** tb/eeprom_i2c_slave_bench.sv ***
`timescale 1ns/10ps
module eeprom_i2c_slave_bench;
  import eeprom_pkg::*;
  localparam logic [3:0] DEV_ID = 4'h6; // Arbitrary value
  localparam int SHORT = 300;
  localparam int LONG = 600;
  localparam int LIMIT = 60000;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic scl, m_low, sda, ack, ce;
  logic [1:0] sda_out, sda_oe_n, busy;
  pins_t pins [2];
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int run [2] = '{0, 0};
  int last_len [2] = '{0, 0};
  logic [7:0] mem [int];

  always #25 clk_sys = !clk_sys;
  always #6 clk_link = !clk_link;
  // Open drain with pull-up: any party pulling low wins
  assign sda = !m_low & (sda_oe_n[0] | sda_out[0]) & (sda_oe_n[1] | sda_out[1]);

  eeprom_i2c_slave #(.DEVICE_TYPE_ID(DEV_ID), .WC_VARIANT(1'b0), .WRITE_CYCLES(SHORT), .WRITE_LONG_CYCLES(LONG))
  u_eeprom_i2c_slave (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out[0]), .sda_oe_n(sda_oe_n[0]), .pins(pins[0]), .busy(busy[0]));
  eeprom_i2c_slave #(.DEVICE_TYPE_ID(DEV_ID), .WC_VARIANT(1'b1), .WRITE_CYCLES(SHORT), .WRITE_LONG_CYCLES(LONG))
  u_eeprom_i2c_slave_wc (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out[1]), .sda_oe_n(sda_oe_n[1]), .pins(pins[1]), .busy(busy[1]));
  i2c_host u_i2c_host (.scl(scl), .sda_low(m_low), .sda(sda));

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    for (int d = 0; d < 2; d++) begin
      if (busy[d] === 1'b1) begin
        run[d] <= run[d] + 1;
      end else if (run[d] > 0) begin
        last_len[d] <= run[d];
        run[d] <= 0;
      end
    end
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] sel(input int d, input logic [9:0] a, input logic rw);
    return {DEV_ID, ce ^ d[0], a[9:8], rw};
  endfunction

  function automatic logic prot(input int d, input logic [9:0] x);
    int k;
    k = 1024 * d + 1023;
    return pins[d].protect_enable && mem.exists(k) && !mem[k][2] && x >= {2'h3, mem[k][7:4], 4'h0};
  endfunction

  task automatic poll(input int d, input logic exp);
    u_i2c_host.start();
    u_i2c_host.wr_byte(sel(d, 10'h0, 1'b0), ack);
    check(ack, exp, "poll");
    u_i2c_host.stop();
  endtask

  task automatic wr(input int d, input logic [9:0] a, input int n, input int fixed);
    logic [7:0] b;
    logic [9:0] x;
    logic mb, lng;
    mb = (d == 0) && pins[0].mode;
    x = a + 10'(n - 1);
    lng = mb && (x[9:3] != a[9:3]);
    u_i2c_host.start();
    u_i2c_host.wr_byte(sel(d, a, 1'b0), ack);
    check(ack, 1'b1, "select");
    u_i2c_host.wr_byte(a[7:0], ack);
    check(ack, 1'b1, "address");
    for (int i = 0; i < n; i++) begin
      b = fixed < 0 ? 8'($urandom) : 8'(fixed);
      x = mb ? a + 10'(i) : {a[9:4], a[3:0] + 4'(i)};
      if (!(d == 1 && pins[1].write_control) && !prot(d, x)) mem[1024 * d + x] = b;
      u_i2c_host.wr_byte(b, ack);
      check(ack, 1'b1, "data");
    end
    u_i2c_host.stop();
    poll(d, 1'b0);
    for (int t = 0; t < 3000 && busy[d] !== 1'b0; t++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(16'(last_len[d]), lng ? 16'(LONG) : 16'(SHORT), "write time");
    poll(d, 1'b1);
  endtask

  task automatic rd(input int d, input logic [9:0] a, input int n);
    logic [7:0] b;
    logic [9:0] x;
    u_i2c_host.start();
    u_i2c_host.wr_byte(sel(d, a, 1'b0), ack);
    u_i2c_host.wr_byte(a[7:0], ack);
    u_i2c_host.start();
    u_i2c_host.wr_byte(sel(d, a, 1'b1), ack);
    check(ack, 1'b1, "read select");
    for (int i = 0; i < n; i++) begin
      x = a + 10'(i);
      u_i2c_host.rd_byte(i < n - 1, b);
      if (mem.exists(1024 * d + x)) check(b, mem[1024 * d + x], "read data");
    end
    u_i2c_host.stop();
  endtask

  task automatic nack_sel(input logic [7:0] s);
    u_i2c_host.start();
    u_i2c_host.wr_byte(s, ack);
    check(ack, 1'b0, "foreign select");
    u_i2c_host.wr_byte(8'h00, ack);
    check(ack, 1'b0, "ignored byte");
    u_i2c_host.stop();
  endtask

  initial begin
    logic [9:0] a;
    void'($urandom(32'h84cf));
    ce = 1'($urandom);
    pins[0] = '{chip_enable: ce, protect_enable: 1'b0, mode: 1'b1, write_control: 1'b0};
    pins[1] = '{chip_enable: !ce, protect_enable: 1'b0, mode: 1'b1, write_control: 1'b0};
    // Two cycles still span several link edges, enough for the reset sync
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    nack_sel({DEV_ID ^ 4'h1, ce, 3'h0});
    @(negedge clk_sys);
    pins[1].chip_enable = ce;
    nack_sel({DEV_ID, !ce, 3'h0});
    @(negedge clk_sys);
    pins[1].chip_enable = !ce;
    pins[0].mode = 1'($urandom);
    a = 10'($urandom);
    wr(0, a, 1, -1);
    rd(0, a, 1);
    @(negedge clk_sys);
    pins[0].mode = 1'b0;
    a = 10'($urandom);
    wr(0, a, 18, -1);
    rd(0, {a[9:4], 4'h0}, 16);
    @(negedge clk_sys);
    pins[0].mode = 1'b1;
    for (int j = 0; j < 2; j++) begin
      a = {7'($urandom), j ? 3'h5 : 3'h0};
      wr(0, a, 6, -1);
      rd(0, a, 6);
    end
    // Write control part ignores multibyte mode and, with the pin high, blocks writes
    a = {6'($urandom), 4'hE};
    for (int j = 0; j < 2; j++) begin
      @(negedge clk_sys);
      pins[1].write_control = 1'(j);
      wr(1, a, 4, -1);
      u_i2c_host.q = 600;
      rd(1, {a[9:4], 4'h0}, 16);
      u_i2c_host.q = 150;
    end
    @(negedge clk_sys);
    pins[0].mode = 1'b0;
    wr(0, 10'h3C5, 1, -1);
    wr(0, 10'h3FF, 1, 'hC0);
    for (int j = 0; j < 3; j++) begin
      @(negedge clk_sys);
      pins[0].protect_enable = (j < 2);
      a = j == 1 ? 10'h3B5 : 10'h3C5;
      wr(0, a, 1, -1);
      rd(0, a, 1);
    end
    // Flag bit set lifts the protection even with the pin high
    wr(0, 10'h3FF, 1, 'hC4);
    @(negedge clk_sys);
    pins[0].protect_enable = 1'b1;
    wr(0, 10'h3C5, 1, -1);
    rd(0, 10'h3C5, 1);
    complete_run();
  end
endmodule
